// File: core/dma_ctl_pkg.sv
// constants shared by the dma channel control block
package dma_ctl_pkg;

    localparam int CH_NUM = 10;

    // control register byte addresses, indexed by channel
    localparam logic [31:0] CTRL_OFS [CH_NUM] = '{
        32'h0080_0410, 32'h0080_0420, 32'h0080_0430, 32'h0080_0440,
        32'h0080_0450, 32'h0080_0418, 32'h0080_0428, 32'h0080_0438,
        32'h0080_0448, 32'h0080_0458};

    // software request words, one per channel
    localparam logic [31:0] SWREQ_BASE   = 32'h0080_0500;
    localparam logic [31:0] SWREQ_STRIDE = 32'h0000_0004;

    // control register fields
    localparam int MODE_BIT  = 0;
    localparam int REQF_BIT  = 1;
    localparam int CAUSE_LSB = 2;
    localparam int EN_BIT    = 4;
    localparam int SIZE_BIT  = 5;
    localparam int SRC_BIT   = 6;
    localparam int DST_BIT   = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // request cause codes
    localparam logic [1:0] CAUSE_00 = 2'h0;
    localparam logic [1:0] CAUSE_01 = 2'h1;
    localparam logic [1:0] CAUSE_10 = 2'h2;
    localparam logic [1:0] CAUSE_11 = 2'h3;

    // last ring buffer count before the wrap (ring of 32 transfers)
    localparam logic [4:0] RING_LAST = 5'h1F;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/dma_channel_control.sv
// ten-channel dma control registers, per-channel request handling, axi4-lite slave
// How it works
// - 8-bit control register with fixed bit layout
// - mode bit: 0 normal, 1 ring buffer
// - ring mode wraps every 32, no END_EVT; channel 0 end still feeds channel 5 cause 01
// - request flag reads pending request state
// - writing 0 clears flag, 1 is ignored
// - request sets flag; blocked while transfer runs
// - channel 0 cause decode
// - channel 1 cause decode, code 10 inhibited
// - channel 2 cause decode
// - channel 3 cause decode
// - channel 4 cause decode
// - channel 5 cause decode
// - channel 6 cause decode, code 10 inhibited
// - channel 7 cause decode, code 10 inhibited
// - channel 8 cause decode, 10/11 inhibited
// - enable bit readies or disables the channel
// - disable never aborts an accepted transfer
// - unit size: 0 sixteen bits, 1 eight
// - address direction bits: 0 fixed, 1 increment
// - software request write raises request on cause 00
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps

module dma_channel_control
    import dma_ctl_pkg::*;
(
    // clock, reset, enable
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    input  wire logic        CE,
    // axi4-lite write address
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    // axi4-lite write data
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // axi4-lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // axi4-lite read
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // peripheral request events, one-cycle pulses
    input  wire logic        CONV0_DONE,
    input  wire logic        TMR_UNDERFLOW,
    input  wire logic        TMR_IN_BUS0,
    input  wire logic        TMR_IN_BUS2,
    input  wire logic        TMR_OUT_BUS0,
    input  wire logic        TMR_OUT_BUS1,
    input  wire logic        TMR_IN0,
    input  wire logic        TMR_IN18,
    input  wire logic        TMR_IN19,
    input  wire logic        TMR_IN20,
    input  wire logic        SIO0_TX_EMPTY,
    input  wire logic        SIO1_TX_EMPTY,
    input  wire logic        SIO2_TX_EMPTY,
    input  wire logic        SIO0_RX_DONE,
    input  wire logic        SIO1_RX_DONE,
    input  wire logic        SIO2_RX_DONE,
    // transfer engine handshake
    output logic [9:0]       XFER_REQ,
    input  wire logic [9:0]  XFER_DONE,
    input  wire logic [9:0]  XFER_END,
    output logic [9:0]       RING_WRAP,
    output logic [9:0]       END_EVT,
    output logic [9:0]       BUSY,
    // channel configuration to the engine
    output logic [9:0]       RING_MODE,
    output logic [9:0]       UNIT_8BIT,
    output logic [9:0]       SRC_INC,
    output logic [9:0]       DST_INC
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [CH_NUM-1:0][7:0] ctrl;
        logic [CH_NUM-1:0][4:0] ring_cnt;
        logic [CH_NUM-1:0]      busy;
        logic [CH_NUM-1:0]      xfer_req;
        logic [CH_NUM-1:0]      ring_wrap;
        logic [CH_NUM-1:0]      end_evt;
        logic                   aw_held;
        logic [31:0]            aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   awready;
        logic                   wready;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    // bus timing: a write is answered at the same edge that takes the later of
    // aw and w, a read at the edge that takes ar; both readies stay low while an
    // answer is outstanding, so only one write and one read are in flight
    // and no skid storage is needed

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by read and write paths
    function automatic logic [4:0] ctrl_hit(input logic [31:0] addr);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < CH_NUM; i++)
        begin
            if (addr == CTRL_OFS[i])
            begin
                res = {1'b1, i[3:0]};
            end
        end
        return res;
    endfunction

    function automatic logic [4:0] swreq_hit(input logic [31:0] addr);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < CH_NUM; i++)
        begin
            if (addr == SWREQ_BASE + SWREQ_STRIDE * i[31:0])
            begin
                res = {1'b1, i[3:0]};
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-channel cause sources, indexed by cause code
    logic [CH_NUM-1:0][3:0] cause_src;
    logic [CH_NUM-1:0]      sw_wr;
    logic [CH_NUM-1:0]      done_eff;
    logic [CH_NUM-1:0]      cause_evt;
    logic                   wr_fire;
    logic [4:0]             wr_ctrl;
    logic [4:0]             wr_sw;

    always_comb
    begin
        wr_fire = (state_r.aw_held | (AWVALID & state_r.awready))
                & (state_r.w_held | (WVALID & state_r.wready))
                & ~state_r.bvalid;
        wr_ctrl = ctrl_hit(state_r.aw_held ? state_r.aw_addr : AWADDR);
        wr_sw   = swreq_hit(state_r.aw_held ? state_r.aw_addr : AWADDR);
        sw_wr   = '0;
        // any write with any lane strobed counts as a software request
        if (wr_fire && wr_sw[4] &&
            ((state_r.w_held ? state_r.w_strb : WSTRB) != 4'h0))
        begin
            sw_wr[wr_sw[3:0]] = 1'b1;
        end
        // a done only counts for a transfer that was really accepted
        done_eff = XFER_DONE & state_r.busy;
    end

    // cause tables: bit k of an entry is the source for cause code k.
    // codes that software must not program are tied low, so a stray
    // setting simply never requests; channel 9 has no external sources
    // and only chains on channel 8

    always_comb
    begin
        cause_src[0] = {TMR_IN_BUS2, TMR_UNDERFLOW, CONV0_DONE,
                        sw_wr[0] | done_eff[2]};
        cause_src[1] = {done_eff[0], 1'b0, TMR_OUT_BUS0, sw_wr[1]};
        cause_src[2] = {done_eff[1], TMR_IN18, TMR_OUT_BUS1,
                        sw_wr[2]};
        cause_src[3] = {TMR_IN0, SIO1_RX_DONE, SIO0_TX_EMPTY,
                        sw_wr[3]};
        cause_src[4] = {TMR_IN19, SIO0_RX_DONE, done_eff[3],
                        sw_wr[4]};
        cause_src[5] = {TMR_IN20, SIO2_RX_DONE,
                        XFER_END[0] & state_r.busy[0],
                        sw_wr[5] | done_eff[7]};
        cause_src[6] = {done_eff[5], 1'b0, SIO1_TX_EMPTY,
                        sw_wr[6]};
        cause_src[7] = {done_eff[6], 1'b0, SIO2_TX_EMPTY,
                        sw_wr[7]};
        cause_src[8] = {2'b00, TMR_IN_BUS0, sw_wr[8]};
        cause_src[9] = {done_eff[8], 2'b00, sw_wr[9]};
    end

    // chained sources are single-cycle done pulses, so one per unit
    genvar gc;
    generate
        for (gc = 0; gc < CH_NUM; gc++)
        begin : g_cause
            assign cause_evt[gc] = cause_src[gc][
                state_r.ctrl[gc][CAUSE_LSB+1:CAUSE_LSB]];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] rd_ctrl;
    logic [4:0] rd_sw;

    always_comb
    begin
        state_nxt = state_r;
        rd_ctrl   = ctrl_hit(ARADDR);
        rd_sw     = swreq_hit(ARADDR);
        state_nxt.xfer_req  = '0;
        state_nxt.ring_wrap = '0;
        state_nxt.end_evt   = '0;

        // write channel capture
        if (AWVALID && state_r.awready)
        begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = AWADDR;
        end
        if (WVALID && state_r.wready)
        begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = WDATA;
            state_nxt.w_strb = WSTRB;
        end
        if (state_r.bvalid && BREADY)
        begin
            state_nxt.bvalid = 1'b0;
        end

        // software side of the control registers
        if (wr_fire)
        begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held  = 1'b0;
            state_nxt.bvalid  = 1'b1;
            state_nxt.bresp   = (wr_ctrl[4] | wr_sw[4]) ? RESP_OKAY
                                                        : RESP_SLVERR;
            if (wr_ctrl[4] &&
                (state_r.w_held ? state_r.w_strb[0] : WSTRB[0]))
            begin
                // software can only clear the flag, never set it
                state_nxt.ctrl[wr_ctrl[3:0]] =
                    {(state_r.w_held ? state_r.w_data[7:2] : WDATA[7:2]),
                     state_r.ctrl[wr_ctrl[3:0]][REQF_BIT] &
                     (state_r.w_held ? state_r.w_data[REQF_BIT]
                                     : WDATA[REQF_BIT]),
                     (state_r.w_held ? state_r.w_data[MODE_BIT]
                                     : WDATA[MODE_BIT])};
            end
        end
        state_nxt.awready = ~state_nxt.aw_held & ~state_nxt.bvalid;
        state_nxt.wready  = ~state_nxt.w_held & ~state_nxt.bvalid;

        // read channel
        if (state_r.rvalid && RREADY)
        begin
            state_nxt.rvalid = 1'b0;
        end
        if (ARVALID && state_r.arready)
        begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp  = (rd_ctrl[4] | rd_sw[4]) ? RESP_OKAY
                                                       : RESP_SLVERR;
            state_nxt.rdata  = rd_ctrl[4]
                ? {24'h00_0000, state_r.ctrl[rd_ctrl[3:0]]}
                : 32'h0000_0000;
        end
        state_nxt.arready = ~state_nxt.rvalid;

        // a request is taken in two steps: the cause sets the flag at one
        // edge, and an enabled, idle channel turns the flag into a
        // transfer request at the next; the flag stays up until the unit
        // is done, so software can see that a request is still pending
        // trade-off: a cause that arrives while busy is dropped, not
        // queued, which matches the one-pending-request flag
        // request handling per channel, after software writes so that a
        // hardware set in the same cycle wins over a software clear
        for (int n = 0; n < CH_NUM; n++)
        begin
            if (done_eff[n])
            begin
                state_nxt.busy[n] = 1'b0;
                state_nxt.ctrl[n][REQF_BIT] = 1'b0;
                if (state_r.ctrl[n][MODE_BIT])
                begin
                    // ring restarts every 32 units, count runs on
                    state_nxt.ring_cnt[n] = state_r.ring_cnt[n] + 5'h01;
                    if (state_r.ring_cnt[n] == RING_LAST)
                    begin
                        state_nxt.ring_wrap[n] = 1'b1;
                    end
                end
            end
            if (!state_r.ctrl[n][MODE_BIT])
            begin
                state_nxt.ring_cnt[n] = 5'h00;
            end
            // completion event is suppressed in ring mode
            state_nxt.end_evt[n] = XFER_END[n] & state_r.busy[n]
                                 & ~state_r.ctrl[n][MODE_BIT];
            // no new request while a transfer is under way
            if (cause_evt[n] && (!state_r.busy[n] || done_eff[n]))
            begin
                state_nxt.ctrl[n][REQF_BIT] = 1'b1;
            end
            // accept only when enabled; a running one is never aborted
            if (state_r.ctrl[n][REQF_BIT] && state_r.ctrl[n][EN_BIT] &&
                !state_r.busy[n] && !done_eff[n])
            begin
                state_nxt.busy[n]     = 1'b1;
                state_nxt.xfer_req[n] = 1'b1;
            end
        end
    end

    // clock enable low freezes everything, the bus handshake included,
    // so a master must not count cycles while the block is held;
    // the asynchronous reset clears all state, flags included

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_r      <= '0;
            state_r.ctrl <= {CH_NUM{CTRL_RST}};
        end
        else if (CE)
        begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from state flops
    // the engine gets the configuration bits as levels; it must sample
    // them when it starts a unit, since software may change them at any
    // time, even while a transfer is under way
    assign AWREADY   = state_r.awready;
    assign WREADY    = state_r.wready;
    assign BVALID    = state_r.bvalid;
    assign BRESP     = state_r.bresp;
    assign ARREADY   = state_r.arready;
    assign RVALID    = state_r.rvalid;
    assign RDATA     = state_r.rdata;
    assign RRESP     = state_r.rresp;
    assign XFER_REQ  = state_r.xfer_req;
    assign RING_WRAP = state_r.ring_wrap;
    assign END_EVT   = state_r.end_evt;
    assign BUSY      = state_r.busy;

    genvar go;
    generate
        for (go = 0; go < CH_NUM; go++)
        begin : g_cfg
            assign RING_MODE[go] = state_r.ctrl[go][MODE_BIT];
            assign UNIT_8BIT[go] = state_r.ctrl[go][SIZE_BIT];
            assign SRC_INC[go]   = state_r.ctrl[go][SRC_BIT];
            assign DST_INC[go]   = state_r.ctrl[go][DST_BIT];
        end
    endgenerate

endmodule // dma_channel_control

// File: verification/dma_ctl_chk.sv
// concurrent checks on the dma channel control ports
`timescale 1ns/10ps

module dma_ctl_chk
    import dma_ctl_pkg::*;
(
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        ARST_N,
    // register bus
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        BVALID,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  RRESP,
    input wire logic        RVALID,
    // engine side
    input wire logic [9:0]  XFER_REQ,
    input wire logic [9:0]  XFER_DONE,
    input wire logic [9:0]  RING_WRAP,
    input wire logic [9:0]  END_EVT,
    input wire logic [9:0]  BUSY,
    input wire logic [9:0]  RING_MODE,
    input wire logic [9:0]  UNIT_8BIT,
    input wire logic [9:0]  SRC_INC,
    input wire logic [9:0]  DST_INC
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    chk_req_busy: assert property ((XFER_REQ & ~BUSY) == '0)
        else $error("request without busy");
    chk_req_single: assert property (|XFER_REQ |=>
        (XFER_REQ & $past(XFER_REQ)) == '0)
        else $error("request longer than one cycle");
    chk_busy_held: assert property (|(BUSY & ~XFER_DONE) |=>
        (~BUSY & $past(BUSY & ~XFER_DONE)) == '0)
        else $error("busy dropped before done");
    chk_cfg_write: assert property (!$rose(BVALID) |->
        $stable({RING_MODE, UNIT_8BIT, SRC_INC, DST_INC}))
        else $error("config moved without a write");
    chk_ar_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read not answered");
    chk_rdata_top: assert property (RVALID |-> RDATA[31:8] == '0)
        else $error("upper read bits not zero");
    chk_wrap_ring: assert property (|RING_WRAP |->
        (RING_WRAP & ~($past(XFER_DONE) & RING_MODE)) == '0)
        else $error("wrap outside ring mode");
    chk_end_normal: assert property ((END_EVT & RING_MODE) == '0)
        else $error("completion in ring mode");

    cover property (|XFER_REQ);
    cover property (|RING_WRAP);
    cover property (RVALID && RRESP == RESP_SLVERR);
endmodule // dma_ctl_chk

// File: verification/xfer_engine_model.sv
// transfer engine stand-in answering each accepted request after a delay
`timescale 1ns/10ps

module xfer_engine_model (
    // clock and reset
    input  wire logic       CLOCK,
    input  wire logic       ARST_N,
    // handshake with the control block
    input  wire logic [9:0] XFER_REQ,
    input  wire logic [3:0] lat,
    output logic      [9:0] XFER_DONE,
    output logic      [9:0] XFER_END
);
    logic [9:0][3:0] wait_r;
    logic [9:0][1:0] units_r;
    logic [9:0]      act_r;

    // count runs free in every mode: end every 4 units, ring mode too
    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
            {wait_r, units_r, act_r, XFER_DONE, XFER_END} <= '0;
        else
            for (int i = 0; i < 10; i++)
            begin
                XFER_DONE[i] <= act_r[i] && wait_r[i] == 4'h0;
                XFER_END[i]  <= act_r[i] && wait_r[i] == 4'h0
                                && units_r[i] == 2'h3;
                if (XFER_REQ[i])
                begin
                    act_r[i]  <= 1'b1;
                    wait_r[i] <= lat;
                end
                else if (act_r[i] && wait_r[i] == 4'h0)
                begin
                    act_r[i]   <= 1'b0;
                    units_r[i] <= units_r[i] + 2'h1;
                end
                else if (act_r[i])
                    wait_r[i] <= wait_r[i] - 4'h1;
            end
    end
endmodule // xfer_engine_model

// File: verification/dma_channel_control_test.sv
// self-checking bench for the dma channel control block
`timescale 1ns/10ps

module dma_channel_control_test;
    import dma_ctl_pkg::*;

    logic        CLOCK, ARST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rdata_q;
    logic [3:0]  WSTRB, lat;
    logic [1:0]  BRESP, RRESP, bresp_q, rresp_q;
    logic [15:0] ev;
    logic [9:0]  XFER_REQ, XFER_DONE, XFER_END, RING_WRAP, END_EVT, BUSY;
    logic [9:0]  RING_MODE, UNIT_8BIT, SRC_INC, DST_INC;
    int          errors, compares, wraps, ends, hits [10];
    wire  [3:0]  cfg9 = {RING_MODE[9], UNIT_8BIT[9], SRC_INC[9], DST_INC[9]};

    dma_channel_control i_dut (.*, .CE(1'b1), .CONV0_DONE(ev[0]),
        .TMR_UNDERFLOW(ev[1]), .TMR_IN_BUS0(ev[2]), .TMR_IN_BUS2(ev[3]),
        .TMR_OUT_BUS0(ev[4]), .TMR_OUT_BUS1(ev[5]), .TMR_IN0(ev[6]),
        .TMR_IN18(ev[7]), .TMR_IN19(ev[8]), .TMR_IN20(ev[9]),
        .SIO0_TX_EMPTY(ev[10]), .SIO1_TX_EMPTY(ev[11]),
        .SIO2_TX_EMPTY(ev[12]), .SIO0_RX_DONE(ev[13]),
        .SIO1_RX_DONE(ev[14]), .SIO2_RX_DONE(ev[15]));
    xfer_engine_model i_eng (.*);

    initial
    begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK)
    begin
        for (int i = 0; i < 10; i++)
            hits[i] += int'(XFER_REQ[i] === 1'b1);
        wraps += int'(RING_WRAP[2] === 1'b1);
        ends += int'(END_EVT[2] === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmpn(input int got, input int exp);
        cmp(34'(got), 34'(exp));
    endtask

    task automatic clr();
        foreach (hits[i]) hits[i] = 0;
        wraps = 0;
        ends = 0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge CLOCK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) break;
        end
        bresp_q = BRESP;
        BREADY <= 1'b0;
        // let an edge pass so a following call never re-drives it at once
        @(posedge CLOCK);
        if (n == 50) errors++;
    endtask

    task automatic rd_cmp(input logic [31:0] a, input logic [33:0] exp);
        int n;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge CLOCK);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) break;
        end
        {rresp_q, rdata_q} = {RRESP, RDATA};
        RREADY <= 1'b0;
        @(posedge CLOCK);
        if (n == 50) errors++;
        cmp({rresp_q, rdata_q}, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int c = 0; c < CH_NUM; c++)
            rd_cmp(CTRL_OFS[c], {RESP_OKAY, 24'h0, CTRL_RST});
        rd_cmp(32'h0080_0404, {RESP_SLVERR, 32'h0});
        wr(32'h0080_0404, 32'hFF);
        cmpn(int'(bresp_q === RESP_SLVERR), 1);
        $display("reset values done");
    endtask

    task automatic t_fields();
        wr(CTRL_OFS[9], 32'hFF);
        rd_cmp(CTRL_OFS[9], {RESP_OKAY, 32'hFD});
        cmpn(int'(cfg9 === 4'hF), 1);
        wr(CTRL_OFS[9], 32'h00);
        cmpn(int'(cfg9 === 4'h0), 1);
        $display("fields done");
    endtask

    // entry: channel, cause code, event index (31 pulses every event)
    task automatic t_causes();
        logic [10:0] tbl [21] = '{11'h020, 11'h041, 11'h063, 11'h0A4,
            11'h125, 11'h147, 11'h1AA, 11'h1CE, 11'h1E6, 11'h24D, 11'h268,
            11'h2CF, 11'h2E9, 11'h32B, 11'h3AC, 11'h422, 11'h0DF, 11'h35F,
            11'h3DF, 11'h45F, 11'h47F};
        foreach (tbl[k])
        begin
            wr(CTRL_OFS[tbl[k][10:7]], {26'h1, tbl[k][6:5], 2'h0});
            clr();
            ev <= (tbl[k][4:0] == 5'h1F) ? 16'hFFFF : 16'h1 << tbl[k][4:0];
            @(posedge CLOCK);
            ev <= 16'h0;
            repeat (24) @(posedge CLOCK);
            cmpn(hits[tbl[k][10:7]], int'(tbl[k][4:0] != 5'h1F));
            wr(CTRL_OFS[tbl[k][10:7]], 32'h0);
        end
        $display("causes done");
    endtask

    task automatic t_chain();
        wr(CTRL_OFS[0], 32'h10);
        wr(CTRL_OFS[1], 32'h1C);
        clr();
        wr(SWREQ_BASE, 32'h1);
        wr(SWREQ_BASE, 32'h1);
        rd_cmp(CTRL_OFS[0], {RESP_OKAY, 32'h12});
        wr(CTRL_OFS[0], 32'h10);
        rd_cmp(CTRL_OFS[0], {RESP_OKAY, 32'h10});
        repeat (60) @(posedge CLOCK);
        cmpn(hits[0], 1);
        cmpn(hits[1], 1);
        wr(CTRL_OFS[0], 32'h0);
        wr(CTRL_OFS[1], 32'h0);
        $display("chain done");
    endtask

    task automatic t_disable();
        wr(CTRL_OFS[3], 32'h10);
        clr();
        wr(SWREQ_BASE + 32'hC, 32'h1);
        wr(CTRL_OFS[3], 32'h00);
        cmpn(int'(BUSY[3] === 1'b1), 1);
        repeat (40) @(posedge CLOCK);
        cmpn(int'(BUSY[3] === 1'b0), 1);
        wr(SWREQ_BASE + 32'hC, 32'h1);
        repeat (10) @(posedge CLOCK);
        cmpn(hits[3], 1);
        $display("disable done");
    endtask

    task automatic t_ring();
        lat <= 4'h0;
        wr(CTRL_OFS[2], 32'h11);
        clr();
        for (int k = 0; k < 36; k++)
        begin
            if (k == 32) wr(CTRL_OFS[2], 32'h10);
            wr(SWREQ_BASE + 32'h8, 32'h1);
            repeat (8) @(posedge CLOCK);
        end
        cmpn(hits[2], 36);
        cmpn(wraps, 1);
        cmpn(ends, 1);
        $display("ring done");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, ARST_N} = '0;
        {AWADDR, WDATA, ARADDR, ev} = '0;
        WSTRB = 4'hF;
        lat = 4'hF;
        repeat (8) @(posedge CLOCK);
        ARST_N <= 1'b1;
        repeat (2) @(posedge CLOCK);
        t_reset();
        t_fields();
        t_causes();
        t_chain();
        t_disable();
        t_ring();
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge CLOCK);
        errors++;
        tally_and_finish();
    end
endmodule // dma_channel_control_test

bind dma_channel_control dma_ctl_chk i_chk (.*);
